/* File: common/fta_pkg.sv */
// package: constants and types for the flow totalizer and alarm monitor
package fta_pkg;
    // register byte offsets
    localparam logic [11:0] FTA_CTRL_OFS = 12'h000;
    localparam logic [11:0] FTA_UNIT_OFS = 12'h004;
    localparam logic [11:0] FTA_GAS_OFS = 12'h008;
    localparam logic [11:0] FTA_CALV_OFS = 12'h00c;
    localparam logic [11:0] FTA_TSTART_OFS = 12'h010;
    localparam logic [11:0] FTA_TSTOP_OFS = 12'h014;
    localparam logic [11:0] FTA_TOTAL_OFS = 12'h018;
    localparam logic [11:0] FTA_ALOW_OFS = 12'h01c;
    localparam logic [11:0] FTA_AHIGH_OFS = 12'h020;
    localparam logic [11:0] FTA_ADLY_OFS = 12'h024;
    localparam logic [11:0] FTA_RELAY_OFS = 12'h028;
    localparam logic [11:0] FTA_STAT_OFS = 12'h02c;
    // control field positions
    localparam int FTA_CTRL_TOTEN = 0;
    localparam int FTA_CTRL_ALMEN = 1;
    localparam int FTA_CTRL_TCLR = 2;
    // unit, gas and calibration table limits
    localparam logic [4:0] FTA_UNIT_MAX = 5'h16;
    localparam logic [4:0] FTA_UNIT_RST = 5'h00;
    localparam logic [3:0] FTA_GAS_MAX = 4'h9;
    localparam logic [3:0] FTA_GAS_RST = 4'h0;
    localparam logic [3:0] FTA_GAS_UNCAL = 4'hf;
    localparam logic [9:0] FTA_CALV_RST = 10'h001;
    // flow is in tenths of a percent of full scale
    localparam logic [15:0] FTA_SWAMP_ON = 16'h044c;
    localparam logic [15:0] FTA_SWAMP_OFF = 16'h03e8;
    localparam logic [15:0] FTA_ALOW_RST = 16'h0000;
    localparam logic [15:0] FTA_AHIGH_RST = 16'h03e8;
    localparam logic [11:0] FTA_ADLY_MAX = 12'he10;
    // relay actions
    localparam logic [2:0] FTA_ACT_NONE = 3'h0;
    localparam logic [2:0] FTA_ACT_TOT = 3'h1;
    localparam logic [2:0] FTA_ACT_HIGH = 3'h2;
    localparam logic [2:0] FTA_ACT_LOW = 3'h3;
    localparam logic [2:0] FTA_ACT_RANGE = 3'h4;
    localparam logic [2:0] FTA_ACT_MAN = 3'h5;
    // timebase
    localparam int FTA_CLK_HZ = 100_000_000;
    localparam int FTA_TICK_MS = 1;
    localparam int FTA_MS_CYCLES = FTA_CLK_HZ / 1000 * FTA_TICK_MS;
    localparam int FTA_SEC_S = 1;
    localparam int FTA_SEC_CYCLES = FTA_CLK_HZ * FTA_SEC_S;
    localparam int FTA_PWRUP_MS = 1000;
    localparam int FTA_PWRUP_CYCLES = FTA_CLK_HZ / 1000 * FTA_PWRUP_MS;

    typedef enum logic [1:0] {
        FTA_PU_WATCH = 2'b00,
        FTA_PU_RUN = 2'b01
    } fta_pu_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fta_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fta_apb_rsp_t;

    typedef struct packed {
        logic relay1;
        logic relay2;
        logic swamp;
        logic tot_hit;
        logic alarm_high;
        logic alarm_low;
    } fta_status_t;
endpackage

/* File: design/fta_monitor.sv */
// module: flow totalizer, unit/table selection and flow alarm monitor
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
module fta_monitor #(
    parameter int SEC_CYCLES = fta_pkg::FTA_SEC_CYCLES,
    parameter int MS_CYCLES = fta_pkg::FTA_MS_CYCLES,
    parameter int PWRUP_CYCLES = fta_pkg::FTA_PWRUP_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // apb slave
    input wire fta_pkg::fta_apb_req_t apb_req_in,
    output fta_pkg::fta_apb_rsp_t apb_rsp_out,
    // measurement from the sensor path, same clock
    input wire logic [15:0] flow_pml_in,
    input wire logic [15:0] tot_inc_in,
    // maintenance push button pin, low while pressed
    input wire logic maint_btn_b_in,
    // outputs
    output fta_pkg::fta_status_t status_out,
    output logic [4:0] tot_unit_out,
    output logic [3:0] gas_code_out
);
    import fta_pkg::*;

    typedef struct packed {
        fta_pu_t pu;
        logic [31:0] pu_cnt;
        logic btn_s1;
        logic btn_s2;
        logic [31:0] ms_cnt;
        logic [31:0] sec_cnt;
        logic tot_en;
        logic alm_en;
        logic [4:0] unit;
        logic [3:0] gas;
        logic [9:0] cal_valid;
        logic [15:0] tot_start;
        logic [31:0] tot_stop;
        logic [31:0] total;
        logic [15:0] alm_low;
        logic [15:0] alm_high;
        logic [11:0] alm_dly;
        logic [2:0] act1;
        logic [2:0] act2;
        logic [1:0] latch_mode;
        logic [1:0] latched;
        logic [11:0] hi_cnt;
        logic [11:0] lo_cnt;
        logic swamp;
        logic alm_hi;
        logic alm_lo;
        logic relay1;
        logic relay2;
        logic [31:0] prdata;
        logic pslverr;
    } fta_state_t;

    fta_state_t st_q;
    fta_state_t st_d;

    // flow unit index to totalizer unit code
    function automatic logic [4:0] fta_tot_unit(input logic [4:0] u);
        logic [4:0] r;
        r = 5'h00;
        if (u == 5'h00) begin
            r = 5'h00;
        end else if (u == FTA_UNIT_MAX) begin
            r = 5'h08;
        end else begin
            r = 5'((u - 5'h01) / 5'h03 + 5'h01);
        end
        return r;
    endfunction

    // relay drive for one action code
    function automatic logic fta_act(input logic [2:0] a, input logic hit,
                                     input logic hi, input logic lo,
                                     input logic rng);
        logic r;
        r = 1'b0;
        case (a)
            FTA_ACT_NONE: r = 1'b0;
            FTA_ACT_TOT: r = hit;
            FTA_ACT_HIGH: r = hi;
            FTA_ACT_LOW: r = lo;
            FTA_ACT_RANGE: r = rng;
            FTA_ACT_MAN: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // a high or low alarm action is latchable; tot, range and manual follow their own source
    function automatic logic fta_is_alm(input logic [2:0] a);
        return (a == FTA_ACT_HIGH) || (a == FTA_ACT_LOW);
    endfunction

    logic tot_hit;
    logic wr_en;
    logic setup;
    logic ms_tick;
    logic sec_tick;
    logic hi_cond;
    logic lo_cond;
    logic in_range;
    logic hi_now;
    logic lo_now;
    logic [32:0] tot_sum;
    logic [31:0] rd_val;
    logic rd_hit;
    logic [3:0] gas_code;

    always_comb begin
        st_d = st_q;
        tot_hit = (st_q.tot_stop != 32'h0) &&
                  (st_q.total == st_q.tot_stop);
        setup = apb_req_in.psel && !apb_req_in.penable;
        wr_en = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
        ms_tick = (st_q.ms_cnt == 32'(MS_CYCLES - 1));
        sec_tick = (st_q.sec_cnt == 32'(SEC_CYCLES - 1));
        gas_code = st_q.cal_valid[st_q.gas] ? st_q.gas
                                            : FTA_GAS_UNCAL;
        hi_cond = st_q.alm_en && (flow_pml_in > st_q.alm_high);
        lo_cond = st_q.alm_en && (flow_pml_in < st_q.alm_low);
        hi_now = hi_cond && (st_q.hi_cnt >= st_q.alm_dly);
        lo_now = lo_cond && (st_q.lo_cnt >= st_q.alm_dly);
        in_range = st_q.alm_en && !hi_cond && !lo_cond;
        tot_sum = {1'b0, st_q.total} + {17'h0, tot_inc_in};

        // pin synchroniser
        st_d.btn_s1 = !maint_btn_b_in;
        st_d.btn_s2 = st_q.btn_s1;

        // free running timebases
        st_d.ms_cnt = ms_tick ? 32'h0 : st_q.ms_cnt + 32'h1;
        st_d.sec_cnt = sec_tick ? 32'h0 : st_q.sec_cnt + 32'h1;

        // swamping with hysteresis down to full scale
        if (flow_pml_in > FTA_SWAMP_ON) begin
            st_d.swamp = 1'b1;
        end else if (flow_pml_in <= FTA_SWAMP_OFF) begin
            st_d.swamp = 1'b0;
        end

        // totalizer, saturating at a nonzero stop limit
        if (st_q.tot_en && ms_tick && !tot_hit &&
            (flow_pml_in >= st_q.tot_start)) begin
            if ((st_q.tot_stop != 32'h0) &&
                (tot_sum > {1'b0, st_q.tot_stop})) begin
                st_d.total = st_q.tot_stop;
            end else if (tot_sum[32]) begin
                st_d.total = 32'hffff_ffff;
            end else begin
                st_d.total = tot_sum[31:0];
            end
        end

        // power-up watch of the maintenance button
        case (st_q.pu)
            FTA_PU_WATCH: begin
                st_d.pu_cnt = st_q.pu_cnt + 32'h1;
                if (st_q.pu_cnt == 32'(PWRUP_CYCLES - 1)) begin
                    st_d.pu = FTA_PU_RUN;
                    if (st_q.btn_s2) begin
                        st_d.total = 32'h0;
                    end
                end
            end
            FTA_PU_RUN: st_d.pu = FTA_PU_RUN;
            default: st_d.pu = FTA_PU_WATCH;
        endcase

        // action delay counters restart whenever the flow comes back
        if (!hi_cond) begin
            st_d.hi_cnt = 12'h0;
        end else if (sec_tick && (st_q.hi_cnt < st_q.alm_dly)) begin
            st_d.hi_cnt = st_q.hi_cnt + 12'h1;
        end
        if (!lo_cond) begin
            st_d.lo_cnt = 12'h0;
        end else if (sec_tick && (st_q.lo_cnt < st_q.alm_dly)) begin
            st_d.lo_cnt = st_q.lo_cnt + 12'h1;
        end
        st_d.alm_hi = hi_now;
        st_d.alm_lo = lo_now;

        // register writes
        if (wr_en) begin
            case (apb_req_in.paddr)
                FTA_CTRL_OFS: begin
                    st_d.tot_en = apb_req_in.pwdata[FTA_CTRL_TOTEN];
                    st_d.alm_en = apb_req_in.pwdata[FTA_CTRL_ALMEN];
                    if (apb_req_in.pwdata[FTA_CTRL_TCLR]) begin
                        st_d.total = 32'h0;
                    end
                end
                FTA_UNIT_OFS: begin
                    if (apb_req_in.pwdata[4:0] <= FTA_UNIT_MAX) begin
                        st_d.unit = apb_req_in.pwdata[4:0];
                    end
                end
                FTA_GAS_OFS: begin
                    if (apb_req_in.pwdata[3:0] <= FTA_GAS_MAX) begin
                        st_d.gas = apb_req_in.pwdata[3:0];
                    end
                end
                FTA_CALV_OFS: st_d.cal_valid = apb_req_in.pwdata[9:0];
                FTA_TSTART_OFS: st_d.tot_start = apb_req_in.pwdata[15:0];
                FTA_TSTOP_OFS: st_d.tot_stop = apb_req_in.pwdata;
                FTA_ALOW_OFS: st_d.alm_low = apb_req_in.pwdata[15:0];
                FTA_AHIGH_OFS: st_d.alm_high = apb_req_in.pwdata[15:0];
                FTA_ADLY_OFS: begin
                    if (apb_req_in.pwdata[11:0] <= FTA_ADLY_MAX &&
                        apb_req_in.pwdata[31:12] == 20'h0) begin
                        st_d.alm_dly = apb_req_in.pwdata[11:0];
                    end
                end
                FTA_RELAY_OFS: begin
                    st_d.act1 = apb_req_in.pwdata[2:0];
                    st_d.act2 = apb_req_in.pwdata[6:4];
                    st_d.latch_mode = apb_req_in.pwdata[9:8];
                end
                default: st_d.pslverr = st_q.pslverr;
            endcase
        end

        // latches drop on alarm disable or latch mode change; set wins
        if (!st_d.alm_en || (st_d.latch_mode != st_q.latch_mode)) begin
            st_d.latched = 2'b00;
        end
        if (st_q.latch_mode[0] && fta_is_alm(st_q.act1) &&
            fta_act(st_q.act1, 1'b0, hi_now, lo_now, 1'b0)) begin
            st_d.latched[0] = 1'b1;
        end
        if (st_q.latch_mode[1] && fta_is_alm(st_q.act2) &&
            fta_act(st_q.act2, 1'b0, hi_now, lo_now, 1'b0)) begin
            st_d.latched[1] = 1'b1;
        end
        st_d.relay1 = fta_act(st_q.act1, tot_hit, hi_now, lo_now,
                              in_range) || st_q.latched[0];
        st_d.relay2 = fta_act(st_q.act2, tot_hit, hi_now, lo_now,
                              in_range) || st_q.latched[1];

        // read data is captured in the setup cycle
        rd_hit = 1'b1;
        case (apb_req_in.paddr)
            FTA_CTRL_OFS: rd_val = {30'h0, st_q.alm_en, st_q.tot_en};
            FTA_UNIT_OFS: rd_val = {19'h0, fta_tot_unit(st_q.unit), 3'h0,
                                    st_q.unit};
            FTA_GAS_OFS: rd_val = {20'h0, gas_code, 4'h0,
                                   st_q.gas};
            FTA_CALV_OFS: rd_val = {22'h0, st_q.cal_valid};
            FTA_TSTART_OFS: rd_val = {16'h0, st_q.tot_start};
            FTA_TSTOP_OFS: rd_val = st_q.tot_stop;
            FTA_TOTAL_OFS: rd_val = st_q.total;
            FTA_ALOW_OFS: rd_val = {16'h0, st_q.alm_low};
            FTA_AHIGH_OFS: rd_val = {16'h0, st_q.alm_high};
            FTA_ADLY_OFS: rd_val = {20'h0, st_q.alm_dly};
            FTA_RELAY_OFS: rd_val = {22'h0, st_q.latch_mode, 1'b0,
                                     st_q.act2, 1'b0, st_q.act1};
            FTA_STAT_OFS: rd_val = {22'h0, st_q.latched, in_range,
                                    st_q.relay2, st_q.relay1,
                                    st_q.alm_lo, st_q.alm_hi, tot_hit,
                                    st_q.swamp, 1'b0};
            default: begin
                rd_val = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
        if (setup) begin
            st_d.prdata = apb_req_in.pwrite ? 32'h0 : rd_val;
            st_d.pslverr = !rd_hit;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= '{pu: FTA_PU_WATCH, unit: FTA_UNIT_RST,
                      gas: FTA_GAS_RST, cal_valid: FTA_CALV_RST,
                      alm_low: FTA_ALOW_RST, alm_high: FTA_AHIGH_RST,
                      default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign apb_rsp_out.pready = apb_req_in.psel && apb_req_in.penable;
    assign apb_rsp_out.pslverr = apb_req_in.psel && apb_req_in.penable &&
                                 st_q.pslverr;
    assign apb_rsp_out.prdata = st_q.prdata;
    assign status_out.relay1 = st_q.relay1;
    assign status_out.relay2 = st_q.relay2;
    assign status_out.swamp = st_q.swamp;
    assign status_out.tot_hit = tot_hit;
    assign status_out.alarm_high = st_q.alm_hi;
    assign status_out.alarm_low = st_q.alm_lo;
    assign tot_unit_out = fta_tot_unit(st_q.unit);
    assign gas_code_out = gas_code;
endmodule // fta_monitor

/* File: dv/fta_monitor_asserts.sv */
// checker: concurrent properties on the flow monitor ports
`timescale 1ns/100ps
module fta_monitor_asserts (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // bus
    input wire fta_pkg::fta_apb_req_t apb_req_in,
    input wire fta_pkg::fta_apb_rsp_t apb_rsp_out,
    // measurement and button
    input wire logic [15:0] flow_pml_in,
    input wire logic [15:0] tot_inc_in,
    input wire logic maint_btn_b_in,
    // outputs
    input wire fta_pkg::fta_status_t status_out,
    input wire logic [4:0] tot_unit_out,
    input wire logic [3:0] gas_code_out
);
    import fta_pkg::*;
    logic wr;
    logic [31:0] d;
    logic alm_en_q;
    logic [15:0] hi_q;
    logic [15:0] lo_q;
    logic [11:0] dly_q;
    logic [4:0] unit_q;
    logic [3:0] gas_q;
    logic [9:0] calv_q;
    logic [2:0] act1_q;
    assign d = apb_req_in.pwdata;
    assign wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
    // shadow of the settings the outputs depend on
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            alm_en_q <= 1'b0;
            hi_q <= FTA_AHIGH_RST;
            lo_q <= FTA_ALOW_RST;
            dly_q <= 12'h000;
            unit_q <= FTA_UNIT_RST;
            gas_q <= FTA_GAS_RST;
            calv_q <= FTA_CALV_RST;
            act1_q <= FTA_ACT_NONE;
        end else if (wr) begin
            case (apb_req_in.paddr)
                FTA_CTRL_OFS: alm_en_q <= d[FTA_CTRL_ALMEN];
                FTA_AHIGH_OFS: hi_q <= d[15:0];
                FTA_ALOW_OFS: lo_q <= d[15:0];
                FTA_ADLY_OFS:
                    if (d[11:0] <= FTA_ADLY_MAX && d[31:12] == 20'h0)
                        dly_q <= d[11:0];
                FTA_UNIT_OFS: if (d[4:0] <= FTA_UNIT_MAX) unit_q <= d[4:0];
                FTA_GAS_OFS: if (d[3:0] <= FTA_GAS_MAX) gas_q <= d[3:0];
                FTA_CALV_OFS: calv_q <= d[9:0];
                FTA_RELAY_OFS: act1_q <= d[2:0];
                default: ;
            endcase
        end
    end
    function automatic logic [4:0] pair_f(input logic [4:0] u);
        if (u == 5'h00) return 5'h00;
        if (u == 5'h16) return 5'h08;
        return 5'((u + 5'h02) / 5'h03);
    endfunction
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_hi; alm_en_q && flow_pml_in > hi_q; endsequence
    sequence s_lo; alm_en_q && flow_pml_in < lo_q; endsequence
    property p_swamp_set; flow_pml_in > FTA_SWAMP_ON |=> status_out.swamp;
    endproperty
    a_swamp_set: assert property (p_swamp_set)
        else $error("swamp flag not raised");
    property p_swamp_clr; flow_pml_in <= FTA_SWAMP_OFF |=> !status_out.swamp;
    endproperty
    a_swamp_clr: assert property (p_swamp_clr)
        else $error("swamp flag not cleared");
    property p_swamp_hold;
        flow_pml_in > FTA_SWAMP_OFF && flow_pml_in <= FTA_SWAMP_ON
            |=> status_out.swamp == $past(status_out.swamp);
    endproperty
    a_swamp_hold: assert property (p_swamp_hold)
        else $error("swamp flag moved inside band");
    property p_hi_only;
        status_out.alarm_high |-> $past(alm_en_q && flow_pml_in > hi_q);
    endproperty
    a_hi_only: assert property (p_hi_only)
        else $error("high alarm without cause");
    property p_lo_only;
        status_out.alarm_low |-> $past(alm_en_q && flow_pml_in < lo_q);
    endproperty
    a_lo_only: assert property (p_lo_only)
        else $error("low alarm without cause");
    property p_dly0_hi; s_hi ##0 dly_q == 12'h000 |=> status_out.alarm_high;
    endproperty
    a_dly0_hi: assert property (p_dly0_hi)
        else $error("high alarm late at zero delay");
    property p_dly0_lo; s_lo ##0 dly_q == 12'h000 |=> status_out.alarm_low;
    endproperty
    a_dly0_lo: assert property (p_dly0_lo)
        else $error("low alarm late at zero delay");
    property p_unit; tot_unit_out == pair_f(unit_q); endproperty
    a_unit: assert property (p_unit)
        else $error("totalizer unit not paired");
    property p_gas;
        gas_code_out == (calv_q[gas_q] ? gas_q : FTA_GAS_UNCAL);
    endproperty
    a_gas: assert property (p_gas)
        else $error("gas code wrong");
    property p_man; act1_q == FTA_ACT_MAN |=> status_out.relay1; endproperty
    a_man: assert property (p_man)
        else $error("manual relay not energized");
endmodule // fta_monitor_asserts

bind fta_monitor fta_monitor_asserts u_fta_monitor_asserts (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .apb_req_in(apb_req_in),
    .apb_rsp_out(apb_rsp_out), .flow_pml_in(flow_pml_in),
    .tot_inc_in(tot_inc_in), .maint_btn_b_in(maint_btn_b_in),
    .status_out(status_out), .tot_unit_out(tot_unit_out),
    .gas_code_out(gas_code_out));

/* File: dv/fta_sensor_model.sv */
// partner: sensor path and maintenance button feeding the monitor
`timescale 1ns/100ps
module fta_sensor_model (
    // clock
    input wire logic clock_in,
    // commanded values
    input wire logic [15:0] flow_set_in,
    input wire logic [15:0] inc_set_in,
    input wire logic press_in,
    // monitor inputs
    output logic [15:0] flow_pml_out,
    output logic [15:0] tot_inc_out,
    output logic maint_btn_b_out
);
    always @(posedge clock_in) begin
        flow_pml_out <= flow_set_in;
        tot_inc_out <= inc_set_in;
        // operator holds the button through power-up
        maint_btn_b_out <= !press_in;
    end
endmodule // fta_sensor_model

/* File: dv/testbench.sv */
// testbench: register-level tests of the flow monitor
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
$display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); end end
module testbench;
    import fta_pkg::*;
    logic clock_in;
    logic rst_b_in;
    fta_apb_req_t req;
    fta_apb_rsp_t rsp;
    fta_status_t st;
    logic [15:0] flow_set, inc_set, flow_pml, tot_inc;
    logic press, btn_b, err;
    logic [4:0] tunit;
    logic [3:0] gcode, gx;
    logic [31:0] rd, t1;
    int n_errors, checks;
    logic [11:0] rv_a [8] = '{FTA_CTRL_OFS, FTA_UNIT_OFS, FTA_GAS_OFS,
        FTA_CALV_OFS, FTA_ALOW_OFS, FTA_AHIGH_OFS, FTA_ADLY_OFS, FTA_RELAY_OFS};
    logic [31:0] rv_e [8] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h3e8,
        32'h0, 32'h0};
    logic [15:0] sw_v [5] = '{16'h044d, 16'h044c, 16'h03e9, 16'h03e8,
        16'h044c};
    logic [4:0] sw_e = 5'b11100;
    fta_sensor_model u_fta_sensor_model (.clock_in(clock_in),
        .flow_set_in(flow_set), .inc_set_in(inc_set), .press_in(press),
        .flow_pml_out(flow_pml), .tot_inc_out(tot_inc),
        .maint_btn_b_out(btn_b));
    // short second, tick and power-up counts
    fta_monitor #(.SEC_CYCLES(20), .MS_CYCLES(4), .PWRUP_CYCLES(16))
        u_fta_monitor (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .apb_req_in(req), .apb_rsp_out(rsp), .flow_pml_in(flow_pml),
        .tot_inc_in(tot_inc), .maint_btn_b_in(btn_b), .status_out(st),
        .tot_unit_out(tunit), .gas_code_out(gcode));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] dt);
        @(posedge clock_in);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= dt;
        @(posedge clock_in);
        req.penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clock_in);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] dt);
        apb(1'b1, a, dt);
    endtask
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic do_reset(input logic p);
        rst_b_in <= 1'b0;
        press <= p;
        cyc(3);
        rst_b_in <= 1'b1;
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic [4:0] tpair(input logic [4:0] u);
        if (u == 5'h00) return 5'h00;
        return (u == 5'h16) ? 5'h08 : 5'((u + 5'h02) / 5'h03);
    endfunction
    // whole run is under a thousand cycles
    initial begin
        cyc(20000);
        n_errors++;
        give_verdict();
    end
    initial begin
        req = '0;
        flow_set = 16'h01f4;
        inc_set = 16'h0005;
        press = 1'b0;
        rst_b_in = 1'b0;
        n_errors = 0;
        checks = 0;
        for (int p = 0; p < 2; p++) begin
            do_reset(p[0]);
            wr(FTA_TSTART_OFS, 32'h0);
            wr(FTA_CTRL_OFS, 32'h1);
            cyc(40);
            apb(1'b0, FTA_TOTAL_OFS, 32'h0);
            if (p == 0) t1 = rd;
        end
        `CHK(rd < t1, 1'b1)
        do_reset(1'b0);
        foreach (rv_a[i]) chk_rd(rv_a[i], rv_e[i]);
        apb(1'b0, 12'h030, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        for (int u = 0; u < 23; u++) begin
            wr(FTA_UNIT_OFS, 32'(u));
            chk_rd(FTA_UNIT_OFS, {19'h0, tpair(5'(u)), 3'h0, 5'(u)});
            `CHK(tunit, tpair(5'(u)))
        end
        wr(FTA_UNIT_OFS, 32'h17);
        chk_rd(FTA_UNIT_OFS, 32'h0816);
        wr(FTA_CALV_OFS, 32'h005);
        for (int g = 0; g < 10; g++) begin
            wr(FTA_GAS_OFS, 32'(g));
            gx = (g == 0 || g == 2) ? 4'(g) : FTA_GAS_UNCAL;
            chk_rd(FTA_GAS_OFS, {20'h0, gx, 4'h0, 4'(g)});
            `CHK(gcode, gx)
        end
        wr(FTA_GAS_OFS, 32'ha);
        chk_rd(FTA_GAS_OFS, 32'h0f09);
        foreach (sw_v[i]) begin
            flow_set <= sw_v[i];
            cyc(4);
            `CHK(st.swamp, sw_e[4 - i])
        end
        flow_set <= 16'h0190;
        inc_set <= 16'h0003;
        wr(FTA_TSTART_OFS, 32'h1f4);
        wr(FTA_TSTOP_OFS, 32'h1e);
        wr(FTA_CTRL_OFS, 32'h5);
        cyc(40);
        chk_rd(FTA_TOTAL_OFS, 32'h0);
        flow_set <= 16'h01f4;
        cyc(80);
        chk_rd(FTA_TOTAL_OFS, 32'h1e);
        `CHK(st.tot_hit, 1'b1)
        wr(FTA_RELAY_OFS, 32'h1);
        cyc(3);
        `CHK(st.relay1, 1'b1)
        wr(FTA_CTRL_OFS, 32'h4);
        cyc(20);
        chk_rd(FTA_TOTAL_OFS, 32'h0);
        `CHK(st.relay1, 1'b0)
        wr(FTA_TSTOP_OFS, 32'h0);
        wr(FTA_CTRL_OFS, 32'h1);
        cyc(80);
        `CHK(st.tot_hit, 1'b0)
        apb(1'b0, FTA_TOTAL_OFS, 32'h0);
        `CHK(rd > 32'h1e && rd % 3 == 0, 1'b1)
        wr(FTA_CTRL_OFS, 32'h0);
        wr(FTA_ALOW_OFS, 32'hc8);
        wr(FTA_AHIGH_OFS, 32'h258);
        chk_rd(FTA_AHIGH_OFS, 32'h258);
        wr(FTA_ADLY_OFS, 32'he11);
        chk_rd(FTA_ADLY_OFS, 32'h0);
        wr(FTA_ADLY_OFS, 32'he10);
        chk_rd(FTA_ADLY_OFS, 32'he10);
        wr(FTA_ADLY_OFS, 32'h2);
        wr(FTA_RELAY_OFS, 32'h132);
        flow_set <= 16'h02bc;
        cyc(60);
        `CHK(st.alarm_high, 1'b0)
        wr(FTA_CTRL_OFS, 32'h2);
        cyc(12);
        flow_set <= 16'h01f4;
        cyc(2);
        flow_set <= 16'h02bc;
        cyc(14);
        `CHK(st.alarm_high, 1'b0)
        cyc(36);
        `CHK({st.alarm_high, st.relay1}, 2'b11)
        apb(1'b0, FTA_STAT_OFS, 32'h0);
        `CHK(rd[3], 1'b1)
        flow_set <= 16'h01f4;
        cyc(4);
        `CHK({st.alarm_high, st.relay1}, 2'b01)
        wr(FTA_ADLY_OFS, 32'h0);
        flow_set <= 16'h0064;
        cyc(5);
        `CHK({st.alarm_low, st.relay2}, 2'b11)
        flow_set <= 16'h01f4;
        cyc(5);
        `CHK(st.relay2, 1'b0)
        for (int m = 0; m < 4; m++) begin
            wr(FTA_CTRL_OFS, 32'h0);
            wr(FTA_RELAY_OFS, {22'h0, 2'(m), 8'h22});
            wr(FTA_CTRL_OFS, 32'h2);
            flow_set <= 16'h02bc;
            cyc(5);
            flow_set <= 16'h01f4;
            cyc(5);
            `CHK({st.relay2, st.relay1}, 2'(m))
        end
        wr(FTA_RELAY_OFS, 32'h022);
        cyc(3);
        `CHK({st.relay2, st.relay1}, 2'b00)
        wr(FTA_RELAY_OFS, 32'h045);
        cyc(3);
        `CHK({st.relay2, st.relay1}, 2'b11)
        flow_set <= 16'h02bc;
        cyc(4);
        `CHK({st.relay2, st.relay1}, 2'b01)
        give_verdict();
    end
endmodule // testbench
